//--- design/cabyte_top.sv
// Counter and capture register byte access logic
`default_nettype none

module cabyte_top #(
  parameter int unsigned NUM_CHAN = cabyte_pkg::NUM_CHAN
) (
  // Clock and reset
  input  wire logic                    core_clk_in,
  input  wire logic                    rst_n_in,
  // Register bus
  input  wire cabyte_pkg::cabyte_req_s sfr_req_in,
  output logic [7:0]                   sfr_rdata_out,
  // Control inputs
  input  wire logic                    count_tick_in,
  input  wire logic                    watchdog_enable_bit_in,
  input  wire logic                    reload_select_in,
  input  wire logic [NUM_CHAN-1:0]     pwm_short_mode_in,
  // Channel and counter outputs
  output logic [NUM_CHAN-1:0]          comparator_enable_out,
  output logic [NUM_CHAN-1:0]          compare_match_out,
  output logic [15:0]                  counter_out
);

  logic [15:0]         counter;
  logic [7:0]          snapshot;
  logic [15:0]         capture_value [NUM_CHAN];
  logic [15:0]         reload_value  [NUM_CHAN];
  logic [NUM_CHAN-1:0] comparator_enable;

  cabyte_pkg::cabyte_hit_s low_hit;
  cabyte_pkg::cabyte_hit_s high_hit;

  // Channel address decode
  function automatic cabyte_pkg::cabyte_hit_s find_chan(input logic [7:0] addr, input logic high);
    cabyte_pkg::cabyte_hit_s r;
    r = '0;
    for (int i = 0; i < NUM_CHAN; i++) begin
      if (addr == (high ? cabyte_pkg::ADDR_CAP_HIGH[i] : cabyte_pkg::ADDR_CAP_LOW[i])) begin
        r.hit  = 1'b1;
        r.chan = 3'(i);
      end
    end
    return r;
  endfunction

  // Reload alias selection
  function automatic logic use_reload(input logic [2:0] ch);
    return pwm_short_mode_in[ch] & reload_select_in;
  endfunction

  assign low_hit  = find_chan(sfr_req_in.addr, 1'b0);
  assign high_hit = find_chan(sfr_req_in.addr, 1'b1);

  // Counter and its byte writes
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      counter <= cabyte_pkg::RST_WORD;
    end else begin
      counter <= count_tick_in ? counter + cabyte_pkg::COUNT_STEP : counter;
      if (sfr_req_in.wr && !watchdog_enable_bit_in) begin
        if (sfr_req_in.addr == cabyte_pkg::ADDR_COUNTER_LOW) begin
          counter[7:0] <= sfr_req_in.wdata;
        end
        if (sfr_req_in.addr == cabyte_pkg::ADDR_COUNTER_HIGH) begin
          counter[15:8] <= sfr_req_in.wdata;
        end
      end
    end
  end

  // High byte snapshot
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      snapshot <= cabyte_pkg::RST_BYTE;
    end else if (sfr_req_in.rd && sfr_req_in.addr == cabyte_pkg::ADDR_COUNTER_LOW) begin
      snapshot <= counter[15:8];
    end
  end

  // Capture and reload byte writes
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        capture_value[i] <= cabyte_pkg::RST_WORD;
        reload_value[i]  <= cabyte_pkg::RST_WORD;
      end
    end else if (sfr_req_in.wr) begin
      if (low_hit.hit) begin
        if (use_reload(low_hit.chan)) begin
          reload_value[low_hit.chan][7:0] <= sfr_req_in.wdata;
        end else begin
          capture_value[low_hit.chan][7:0] <= sfr_req_in.wdata;
        end
      end
      if (high_hit.hit) begin
        if (use_reload(high_hit.chan)) begin
          reload_value[high_hit.chan][15:8] <= sfr_req_in.wdata;
        end else begin
          capture_value[high_hit.chan][15:8] <= sfr_req_in.wdata;
        end
      end
    end
  end

  // Comparator enable side effects
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      comparator_enable <= '0;
    end else if (sfr_req_in.wr) begin
      if (low_hit.hit) begin
        comparator_enable[low_hit.chan] <= 1'b0;
      end
      if (high_hit.hit) begin
        comparator_enable[high_hit.chan] <= 1'b1;
      end
    end
  end

  // Compare against running counter
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      compare_match_out <= '0;
    end else begin
      for (int i = 0; i < NUM_CHAN; i++) begin
        compare_match_out[i] <= comparator_enable[i] && (capture_value[i] == counter);
      end
    end
  end

  // Read data
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sfr_rdata_out <= cabyte_pkg::RST_BYTE;
    end else if (sfr_req_in.rd) begin
      if (sfr_req_in.addr == cabyte_pkg::ADDR_COUNTER_LOW) begin
        sfr_rdata_out <= counter[7:0];
      end else if (sfr_req_in.addr == cabyte_pkg::ADDR_COUNTER_HIGH) begin
        sfr_rdata_out <= snapshot;
      end else if (low_hit.hit) begin
        sfr_rdata_out <= use_reload(low_hit.chan) ? reload_value[low_hit.chan][7:0]
                                                  : capture_value[low_hit.chan][7:0];
      end else if (high_hit.hit) begin
        sfr_rdata_out <= use_reload(high_hit.chan) ? reload_value[high_hit.chan][15:8]
                                                   : capture_value[high_hit.chan][15:8];
      end else begin
        sfr_rdata_out <= cabyte_pkg::RST_BYTE;
      end
    end
  end

  // Registered status outputs
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      comparator_enable_out <= '0;
      counter_out           <= cabyte_pkg::RST_WORD;
    end else begin
      comparator_enable_out <= comparator_enable;
      counter_out           <= counter;
    end
  end

endmodule
`default_nettype wire

//--- inc/cabyte_pkg.sv
// Package for the counter array byte access block
`default_nettype none
package cabyte_pkg;
  localparam int unsigned NUM_CHAN = 6;
  localparam int unsigned BYTE_W   = 8;
  localparam int unsigned WORD_W   = 16;

  // Register addresses
  localparam logic [7:0] ADDR_COUNTER_LOW  = 8'hf9;
  localparam logic [7:0] ADDR_COUNTER_HIGH = 8'hfa;
  localparam logic [7:0] ADDR_CAP_LOW  [NUM_CHAN] = '{8'hfb, 8'he9, 8'heb, 8'hed, 8'hfd, 8'hd2};
  localparam logic [7:0] ADDR_CAP_HIGH [NUM_CHAN] = '{8'hfc, 8'hea, 8'hec, 8'hee, 8'hfe, 8'hd3};

  // Reset values and counter step
  localparam logic [7:0]  RST_BYTE = 8'h00;
  localparam logic [15:0] RST_WORD = 16'h0000;
  localparam logic [15:0] COUNT_STEP = 16'h0001;

  // Register bus request
  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } cabyte_req_s;

  // Access decode result
  typedef struct packed {
    logic       hit;
    logic [2:0] chan;
  } cabyte_hit_s;
endpackage
`default_nettype wire

//--- test/cabyte_checker.sv
// Assertion checker for the counter array byte access block
`default_nettype none
module cabyte_checker #(
  parameter int unsigned NUM_CHAN = 6
) (
  input wire logic                    core_clk_in,
  input wire logic                    rst_n_in,
  input wire cabyte_pkg::cabyte_req_s sfr_req_in,
  input wire logic [7:0]              sfr_rdata_out,
  input wire logic                    count_tick_in,
  input wire logic                    watchdog_enable_bit_in,
  input wire logic                    reload_select_in,
  input wire logic [NUM_CHAN-1:0]     pwm_short_mode_in,
  input wire logic [NUM_CHAN-1:0]     comparator_enable_out,
  input wire logic [NUM_CHAN-1:0]     compare_match_out,
  input wire logic [15:0]             counter_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire logic direct0 = !(reload_select_in && pwm_short_mode_in[0]);
  wire logic wr_hi = sfr_req_in.wr && sfr_req_in.addr == 8'hfa;
  sequence s_low_rd; sfr_req_in.rd && sfr_req_in.addr == 8'hf9; endsequence
  sequence s_high_rd; sfr_req_in.rd && sfr_req_in.addr == 8'hfa; endsequence
  a_snap_high: assert property (s_low_rd ##1 s_high_rd |=> sfr_rdata_out == $past(counter_out[15:8]))
    else $error("snapshot byte wrong");
  a_low_read: assert property (s_low_rd |=> sfr_rdata_out == counter_out[7:0])
    else $error("low byte read wrong");
  a_lock_high: assert property (wr_hi && watchdog_enable_bit_in && !count_tick_in |-> ##2 $stable(counter_out))
    else $error("locked write took effect");
  a_open_high: assert property (wr_hi && !watchdog_enable_bit_in |-> ##2 counter_out[15:8] == $past(sfr_req_in.wdata, 2))
    else $error("high byte write lost");
  a_clear_en: assert property (sfr_req_in.wr && sfr_req_in.addr == 8'hfb ##1 !sfr_req_in.wr |-> ##1 !comparator_enable_out[0])
    else $error("enable not cleared");
  a_set_en: assert property (sfr_req_in.wr && sfr_req_in.addr == 8'hfc ##1 !sfr_req_in.wr |-> ##1 comparator_enable_out[0])
    else $error("enable not set");
  a_match_en: assert property (compare_match_out[0] |-> comparator_enable_out[0])
    else $error("match while disabled");
  a_cap_low: assert property (sfr_req_in.wr && sfr_req_in.addr == 8'hfb && direct0 ##1 sfr_req_in.rd && sfr_req_in.addr == 8'hfb && direct0 |=> sfr_rdata_out == $past(sfr_req_in.wdata, 2))
    else $error("capture low readback wrong");
  a_cap_high: assert property (sfr_req_in.wr && sfr_req_in.addr == 8'hfc && direct0 ##1 sfr_req_in.rd && sfr_req_in.addr == 8'hfc && direct0 |=> sfr_rdata_out == $past(sfr_req_in.wdata, 2))
    else $error("capture high readback wrong");
endmodule
bind cabyte_top cabyte_checker #(.NUM_CHAN(NUM_CHAN)) chk (.*);
`default_nettype wire

//--- test/cabyte_top_test.sv
// Self-checking bench for the counter array byte access block
`default_nettype none
`define CHK(nm, e, s) begin compares++; if ((s) !== (e)) begin bad_count++; $display("BAD %s exp %h got %h", nm, e, s); end end
module cabyte_top_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic                    clk = 0, rst_n = 0, tick = 0, wdog = 0, rsel = 0, rd_q = 0;
  cabyte_pkg::cabyte_req_s req = '0;
  logic [5:0]              pwm = 0, en, match;
  logic                    seen_match = 0;
  logic [7:0]              rdata, x, y, lo[6], hi[6], expq[$];
  logic [15:0]             cnt, v;
  int                      bad_count = 0, compares = 0, seed = 41;
  always #25 clk = ~clk;
  cabyte_top dut (.core_clk_in(clk), .rst_n_in(rst_n), .sfr_req_in(req), .sfr_rdata_out(rdata),
    .count_tick_in(tick), .watchdog_enable_bit_in(wdog), .reload_select_in(rsel), .pwm_short_mode_in(pwm),
    .comparator_enable_out(en), .compare_match_out(match), .counter_out(cnt));
  always @(posedge clk) rd_q <= req.rd;
  always @(posedge clk) if (match[0] === 1'b1) seen_match <= 1'b1;
  always @(negedge clk) if (rd_q) begin
    y = expq.pop_front();
    `CHK("rdata", y, rdata)
  end
  task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
    @(negedge clk);
    req = '{a, w, !w, d};
    if (!w) expq.push_back(d);
  endtask
  task automatic idle;
    @(negedge clk);
    req = '0;
  endtask
  task automatic results;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #20000;
    bad_count++;
    results;
  end
  initial begin
    repeat (6) @(posedge clk);
    @(negedge clk) rst_n = 1;
    rsel = 1;
    pwm = 6'h3f;
    x = $random(seed);
    acc(8'hfb, 1'h1, x);
    acc(8'hfb, 1'h0, x);
    acc(8'hfc, 1'h0, 8'h00);
    idle;
    rsel = 0;
    acc(8'hfb, 1'h0, 8'h00);
    for (int i = 0; i < 6; i++) begin
      lo[i] = $random(seed);
      hi[i] = $random(seed);
      acc(cabyte_pkg::ADDR_CAP_LOW[i], 1'h1, lo[i]);
      acc(cabyte_pkg::ADDR_CAP_LOW[i], 1'h0, lo[i]);
      idle;
      `CHK("enable", 1'h0, en[i])
      acc(cabyte_pkg::ADDR_CAP_HIGH[i], 1'h1, hi[i]);
      acc(cabyte_pkg::ADDR_CAP_HIGH[i], 1'h0, hi[i]);
      idle;
      `CHK("enable", 1'h1, en[i])
    end
    v = {hi[0], lo[0]} - 16'h0005;
    acc(8'hf9, 1'h1, v[7:0]);
    acc(8'hfa, 1'h1, v[15:8]);
    acc(8'hf9, 1'h0, v[7:0]);
    acc(8'hfa, 1'h0, v[15:8]);
    idle;
    wdog = 1;
    acc(8'hfa, 1'h1, ~v[15:8]);
    acc(8'hf9, 1'h0, v[7:0]);
    acc(8'hfa, 1'h0, v[15:8]);
    idle;
    wdog = 0;
    tick = 1;
    repeat (20) @(negedge clk);
    tick = 0;
    v = v + 16'h0014;
    acc(8'hf9, 1'h0, v[7:0]);
    acc(8'hfa, 1'h0, v[15:8]);
    idle;
    repeat (3) @(negedge clk);
    `CHK("match", 1'h1, seen_match)
    results;
  end
endmodule
`default_nettype wire
